/* File: core/cor_pkg.sv */
// Package for the comparator offset register bank.
// Assumes one 200 MHz clock and an APB master with 32-bit data.
package cor_pkg;
  localparam logic [7:0] OP_WR_UP = 8'h3d;
  localparam logic [7:0] OP_RD_UP = 8'hbd;
  localparam logic [7:0] OP_WR_DN = 8'h3e;
  localparam logic [7:0] OP_RD_DN = 8'hbe;
  localparam logic [11:0] ADDR_UP = 12'h000;
  localparam logic [11:0] ADDR_DN = 12'h004;
  localparam logic [11:0] ADDR_CTL = 12'h008;
  localparam logic [11:0] ADDR_LVL = 12'h00c;
  localparam logic [15:0] RST_UP = 16'h0000;
  localparam logic [15:0] RST_DN = 16'h0000;
  localparam logic [15:0] REG_MASK = 16'hff7f;
  localparam int CODE_MSB = 6;
  localparam int RET_LSB = 8;
  localparam int RET_MSB = 15;
  localparam int REG_MSB = 15;
  localparam int CTL_POL_BIT = 0;
  localparam int CTL_DN_BIT = 1;
  localparam logic [11:0] LVL_BASE = 12'h480;
  localparam logic [11:0] LVL_FULL = 12'hc00;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_EARLY = 3'b010,
    PH_RET = 3'b100
  } cor_phase_t;
  typedef struct packed {
    logic [15:0] upReg;
    logic [15:0] dnReg;
    logic stopPol;
    logic downMode;
  } cor_regs_t;
endpackage : cor_pkg

/* File: core/cor_level_calc.sv */
// Comparator level arithmetic for the offset register bank.
// Assumes registered inputs from the bank on the same clock.
module cor_level_calc (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [6:0] offsetCode,
  input wire logic [7:0] returnCode,
  input wire logic useReturn,
  input wire logic stopPol,
  output logic [11:0] levelCode,
  output logic signed [8:0] signedOffset
);
  typedef struct packed {
    logic [11:0] level;
    logic signed [8:0] off;
  } cor_lvl_state_t;
  cor_lvl_state_t st_r;
  cor_lvl_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (useReturn) begin
      // Two's complement return value
      st_nxt.off = 9'(signed'(returnCode));
    end else if (stopPol) begin
      st_nxt.off = -9'({2'h0, offsetCode});
    end else begin
      st_nxt.off = 9'({2'h0, offsetCode});
    end
    // Level in units of VCC/3072
    st_nxt.level = 12'(cor_pkg::LVL_BASE + 12'(signed'(st_nxt.off)));
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '{level: cor_pkg::LVL_BASE, off: 9'h000};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign levelCode = st_r.level;
  assign signedOffset = st_r.off;
endmodule : cor_level_calc

/* File: core/cor_offset_regs.sv */
// Comparator offset register bank with APB slave and opcode port.
// Assumes APB master and measurement engine on clk_sys.
//
// Function
// - Upstream code bits 6:0 set offset
// - Rising polarity gives positive offset
// - Falling polarity gives negative offset
// - Level equals VCC times (1152+code)/3072
// - Opcodes 3Eh/BEh access downstream, default 0000h
// - Downstream: return 15:8, code 6:0
// - After t1 downstream, signed return offset
module cor_offset_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic opValid,
  input wire logic [7:0] opCode,
  input wire logic [15:0] opWdata,
  output logic [15:0] opRdata,
  output logic opRvalid,
  input wire logic measStart,
  input wire logic earlyEdgeSeen,
  input wire logic measDone,
  output logic [11:0] compLevel,
  output logic signed [8:0] compOffset,
  output logic [2:0] measPhase
);
  typedef struct packed {
    cor_pkg::cor_regs_t regs;
    cor_pkg::cor_phase_t phase;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [15:0] opRd;
    logic opRv;
    logic [11:0] lvl;
    logic signed [8:0] off;
  } cor_state_t;
  cor_state_t s_r;
  cor_state_t s_nxt;
  logic [11:0] lvlW;
  logic signed [8:0] offW;
  logic [6:0] selCode;
  logic useRet;
  logic apbTake;
  logic selUp;
  logic selDn;
  logic selCtl;
  logic selLvl;
  logic apbMiss;
  logic opWrUp;
  logic opWrDn;
  logic opRdUp;
  logic opRdDn;
  logic [15:0] apbWdata;
  logic [15:0] opWmasked;
  logic [31:0] rdWord;

  // Upstream code unless measuring downstream
  always_comb begin
    selCode = s_r.regs.downMode ? s_r.regs.dnReg[cor_pkg::CODE_MSB:0]
                                : s_r.regs.upReg[cor_pkg::CODE_MSB:0];
    useRet = s_r.regs.downMode && (s_r.phase == cor_pkg::PH_RET);
  end

  cor_level_calc u_calc (
    .clk_sys(clk_sys),
    .rst(rst),
    .offsetCode(selCode),
    .returnCode(s_r.regs.dnReg[cor_pkg::RET_MSB:cor_pkg::RET_LSB]),
    .useReturn(useRet),
    .stopPol(s_r.regs.stopPol),
    .levelCode(lvlW),
    .signedOffset(offW)
  );

  // Address decode; only the access edge of a transfer is taken
  always_comb begin
    apbTake = psel && penable && !s_r.ready;
    selUp = 1'b0;
    selDn = 1'b0;
    selCtl = 1'b0;
    selLvl = 1'b0;
    apbMiss = 1'b0;
    if (apbTake) begin
      case (paddr)
        cor_pkg::ADDR_UP: begin
          selUp = 1'b1;
        end
        cor_pkg::ADDR_DN: begin
          selDn = 1'b1;
        end
        cor_pkg::ADDR_CTL: begin
          selCtl = 1'b1;
        end
        cor_pkg::ADDR_LVL: begin
          selLvl = 1'b1;
        end
        default: begin
          apbMiss = 1'b1;
        end
      endcase
    end
  end

  // Opcode decode; unknown opcodes are dropped silently
  always_comb begin
    opWrUp = 1'b0;
    opWrDn = 1'b0;
    opRdUp = 1'b0;
    opRdDn = 1'b0;
    if (opValid) begin
      case (opCode)
        cor_pkg::OP_WR_UP: begin
          opWrUp = 1'b1;
        end
        cor_pkg::OP_WR_DN: begin
          opWrDn = 1'b1;
        end
        cor_pkg::OP_RD_UP: begin
          opRdUp = 1'b1;
        end
        cor_pkg::OP_RD_DN: begin
          opRdDn = 1'b1;
        end
        default: begin
          opWrUp = 1'b0;
        end
      endcase
    end
  end

  // Bit 7 of upReg and dnReg is never stored, so it cannot read back as one
  always_comb begin
    apbWdata = pwdata[cor_pkg::REG_MSB:0] & cor_pkg::REG_MASK;
    opWmasked = opWdata & cor_pkg::REG_MASK;
    rdWord = 32'h0000_0000;
    if (selUp) begin
      rdWord = {16'h0000, s_r.regs.upReg};
    end else if (selDn) begin
      rdWord = {16'h0000, s_r.regs.dnReg};
    end else if (selCtl) begin
      rdWord = {27'h0, s_r.phase, s_r.regs.downMode, s_r.regs.stopPol};
    end else if (selLvl) begin
      rdWord = {7'h00, s_r.off, 4'h0, s_r.lvl};
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.opRv = 1'b0;
    // Level path lags the registers by two edges
    s_nxt.lvl = lvlW;
    s_nxt.off = offW;
    // APB: one wait state, answer registered
    if (apbTake) begin
      s_nxt.ready = 1'b1;
      s_nxt.err = apbMiss;
      s_nxt.rdata = rdWord;
    end
    // Unmapped and status addresses store nothing
    if (selUp && pwrite) begin
      s_nxt.regs.upReg = apbWdata;
    end
    if (selDn && pwrite) begin
      s_nxt.regs.dnReg = apbWdata;
    end
    if (selCtl && pwrite) begin
      s_nxt.regs.stopPol = pwdata[cor_pkg::CTL_POL_BIT];
      s_nxt.regs.downMode = pwdata[cor_pkg::CTL_DN_BIT];
    end
    // Opcode port last: a same-cycle opcode write wins
    if (opWrUp) begin
      s_nxt.regs.upReg = opWmasked;
    end
    if (opWrDn) begin
      s_nxt.regs.dnReg = opWmasked;
    end
    if (opRdUp) begin
      s_nxt.opRd = s_r.regs.upReg;
      s_nxt.opRv = 1'b1;
    end
    if (opRdDn) begin
      s_nxt.opRd = s_r.regs.dnReg;
      s_nxt.opRv = 1'b1;
    end
    // Measurement phase; start wins over done only in idle
    case (s_r.phase)
      cor_pkg::PH_IDLE: begin
        if (measStart) begin
          s_nxt.phase = cor_pkg::PH_EARLY;
        end
      end
      cor_pkg::PH_EARLY: begin
        if (measDone) begin
          s_nxt.phase = cor_pkg::PH_IDLE;
        end else if (earlyEdgeSeen) begin
          s_nxt.phase = cor_pkg::PH_RET;
        end
      end
      cor_pkg::PH_RET: begin
        if (measDone) begin
          s_nxt.phase = cor_pkg::PH_IDLE;
        end
      end
      default: begin
        s_nxt.phase = cor_pkg::PH_IDLE;
      end
    endcase
  end

  // Flash contents not modelled: reset loads the factory value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '{regs: '{upReg: cor_pkg::RST_UP, dnReg: cor_pkg::RST_DN,
                       stopPol: 1'b0, downMode: 1'b0},
               phase: cor_pkg::PH_IDLE, rdata: 32'h0000_0000,
               ready: 1'b0, err: 1'b0, opRd: 16'h0000, opRv: 1'b0,
               lvl: cor_pkg::LVL_BASE, off: 9'h000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign opRdata = s_r.opRd;
  assign opRvalid = s_r.opRv;
  assign compLevel = s_r.lvl;
  assign compOffset = s_r.off;
  assign measPhase = s_r.phase;
endmodule : cor_offset_regs

/* File: tb/cor_offset_regs_properties.sv */
// Port assertions for the comparator offset bank.
// Assumes binding onto cor_offset_regs, one clock domain.
module cor_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic opValid,
  input wire logic [7:0] opCode,
  input wire logic [15:0] opRdata,
  input wire logic opRvalid,
  input wire logic measStart,
  input wire logic earlyEdgeSeen,
  input wire logic measDone,
  input wire logic [11:0] compLevel,
  input wire logic signed [8:0] compOffset,
  input wire logic [2:0] measPhase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence sAcc; psel && penable && !pready; endsequence
  sequence sRdOp; opValid && (opCode == 8'hbd || opCode == 8'hbe); endsequence
  a_ready_wait: assert property (sAcc |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready long");
  a_op_answer: assert property (sRdOp |=> opRvalid)
    else $error("no read answer");
  a_rsvd_zero: assert property (opRvalid |-> !opRdata[7])
    else $error("bit 7 set");
  a_lvl_sum: assert property (compLevel == 12'h480 + 12'(compOffset))
    else $error("level wrong");
  a_ph_start: assert property (measPhase == 3'b001 && measStart && !measDone
    |=> measPhase == 3'b010) else $error("no early phase");
  a_ph_ret: assert property (measPhase == 3'b010 && earlyEdgeSeen
    && !measDone |=> measPhase == 3'b100) else $error("no return phase");
  a_ph_done: assert property (measDone && !(measPhase == 3'b001 && measStart)
    |=> measPhase == 3'b001) else $error("not idle");
endmodule : cor_properties
bind cor_offset_regs cor_properties u_prop (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .opValid(opValid),
  .opCode(opCode), .opRdata(opRdata), .opRvalid(opRvalid),
  .measStart(measStart), .earlyEdgeSeen(earlyEdgeSeen),
  .measDone(measDone), .compLevel(compLevel), .compOffset(compOffset),
  .measPhase(measPhase));

/* File: tb/cor_host.sv */
// Host model issuing register opcodes.
// Assumes the bank samples opcodes on rising clk_sys edges.
module cor_host (
  input wire logic clk_sys,
  output logic opValid,
  output logic [7:0] opCode,
  output logic [15:0] opWdata,
  input wire logic [15:0] opRdata,
  input wire logic opRvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial opValid = 1'b0;
  // Called at an edge; released data is scrambled, not held
  task automatic op(input logic [7:0] c, input logic [15:0] w,
    output logic [15:0] r);
    opValid <= 1'b1;
    opCode <= c;
    opWdata <= w;
    @(posedge clk_sys);
    opValid <= 1'b0;
    opWdata <= ~w;
    @(posedge clk_sys);
    r = opRvalid ? opRdata : 16'hdead;
  endtask : op
endmodule : cor_host

/* File: tb/tb_comparator_offset_registers.sv */
// Self-checking bench for the comparator offset bank.
// Assumes cor_offset_regs, cor_host and the bound checker.
module tb_comparator_offset_registers;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, opValid, opRvalid, er;
  logic [2:0] ev = 3'b000, measPhase;
  logic [11:0] paddr = 12'h000, compLevel;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h8e30;
  logic [15:0] opWdata, opRdata, r16;
  logic [7:0] opCode;
  logic [7:0] opw[2] = '{8'h3d, 8'h3e};
  logic [2:0] ph[3] = '{3'b010, 3'b100, 3'b001};
  logic signed [8:0] compOffset;
  int mdl[2] = '{0, 0};
  int miscompares = 0, comparisons = 0;
  cor_offset_regs DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opValid(opValid), .opCode(opCode), .opWdata(opWdata),
    .opRdata(opRdata), .opRvalid(opRvalid), .measStart(ev[0]),
    .earlyEdgeSeen(ev[1]), .measDone(ev[2]), .compLevel(compLevel),
    .compOffset(compOffset), .measPhase(measPhase));
  cor_host HOST (.clk_sys(clk_sys), .opValid(opValid), .opCode(opCode),
    .opWdata(opWdata), .opRdata(opRdata), .opRvalid(opRvalid));
  initial forever #2.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Pol negates the code only; return field is two's complement
  function automatic int lvl(input int c, input bit ret);
    int o;
    o = (c[1] ? mdl[1] : mdl[0]) & 127;
    if (c[0]) o = -o;
    if (c[1] && ret) o = ((mdl[1] >> 8) ^ 128) - 128;
    return 1152 + o;
  endfunction : lvl
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic ev_go(input logic [2:0] e);
    ev <= e;
    @(posedge clk_sys);
    ev <= 3'b000;
    repeat (3) @(posedge clk_sys);
  endtask : ev_go
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(32'(compLevel), 32'd1152);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      if (i > 1) mdl[i % 2] = int'(seed[15:0] & 16'hff7f);
      if (i > 1) apb(1'b1, 12'(4 * (i % 2)), seed, rd, er);
      apb(1'b0, 12'(4 * (i % 2)), 32'h0, rd, er);
      chk(rd, mdl[i % 2]);
    end
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    foreach (opw[i]) begin
      seed = lfsr(seed);
      mdl[i] = int'(seed[15:0] & 16'hff7f);
      HOST.op(opw[i], seed[15:0], r16);
      HOST.op(opw[i] | 8'h80, 16'h0000, r16);
      chk(32'(r16), mdl[i]);
    end
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h008, c, rd, er);
      for (int p = 0; p < 3; p++) begin
        ev_go(3'b001 << p);
        chk(32'(compLevel), lvl(c, p == 1));
        chk(32'(compOffset), lvl(c, p == 1) - 1152);
        chk(32'(measPhase), 32'(ph[p]));
      end
    end
    // Mid-run reset must bring back the factory value
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(32'(compLevel), 32'd1152);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk(rd, 32'h0);
    report_and_stop();
  end
  initial begin
    #20us;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_comparator_offset_registers
